// *** verilog/link_power_fsm.sv ***
// Purpose: Link-layer power-mode negotiation with AXI4-Lite control.
// Assumes: rxPrim is decoded each cycle on this clock; phy levels are async.
// Notes: Command bits of the control register act as one-shot requests.
//
// Our own choices: the address map and register access over AXI4-Lite.

`timescale 1ns/100ps

// How it works
// R1: Partial request sends PMREQ_P continuously.
// R2: Slumber request sends PMREQ_S continuously.
// R3: PMACK during request goes to phy check.
// R4: X_RDY aborts request, reports, receive wait.
// R5: SYNC or R_OK keeps request state.
// R6: Device stays on incoming PMREQ; host never.
// R7: Host and device return idle on other dwords.
// R8: Phy loss in request/deny reports error.
// R9: Incoming PMREQ acks, flags which was received.
// R10: Exactly four PMACKs then phy check.
// R11: Disabled power modes answer with PMNACK.
// R12: Deny exits to idle on other dword.
// R13: Phy check drives partial/slumber until PhyRdy drops.
// R14: Wake request or COMWAKE leaves powered down.
// R15: First wakeup clears both, waits PhyRdy.
// R16: Second wakeup sends ALIGN, idles if ready.
// R17: Phy loss in second wakeup reports error.
// R18: Enable bit selects acknowledge or deny.
module link_power_fsm
  import link_pm_pkg::*;
#(
  parameter bit IS_HOST = 1'b0
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire prim_t rxPrim,
  output prim_t txPrim,
  input wire logic phyRdy,
  input wire logic comWake,
  output logic phyPartial,
  output logic phySlumber,
  output logic pmAbort,
  output logic linkErr,
  output logic rcvStart,
  output logic irq
);

  pm_state_t state_r;
  pm_state_t state_nxt;
  logic [1:0] phyIn;
  logic [1:0] phySync;
  logic phyRdyS;
  logic comWakeS;
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic wStrb0_r;
  logic doWrite;
  logic ctrlWr;
  logic pmEnable_r;
  logic [IRQ_W-1:0] irqStat_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic [IRQ_W-1:0] irqEv;
  logic reqPartial;
  logic reqSlumber;
  logic reqWake;
  logic inReq;
  logic rxPmReq;
  logic modeSlumber_r;
  logic [1:0] ackCnt_r;
  logic abortEv;
  logic errEv;
  logic sleepReq;

  // ==========================================================================
  // Phy input synchronisation.
  assign phyIn = {comWake, phyRdy};

  pin_sync #(.W(2)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .din(phyIn),
    .dout(phySync)
  );

  assign phyRdyS = phySync[0];
  assign comWakeS = phySync[1];

  // ==========================================================================
  // AXI4-Lite write channel.
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign ctrlWr = doWrite && (awAddr_r == OFF_CTRL) && wStrb0_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb0_r <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awAddr_r)
          OFF_CTRL, OFF_STATUS, OFF_IRQ_STAT, OFF_IRQ_MASK: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_DECERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Control register and command strobes.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pmEnable_r <= RST_PM_EN;
      irqMask_r <= RST_IRQ_MASK;
    end else begin
      if (ctrlWr) begin
        pmEnable_r <= wData_r[CTRL_PM_EN];
      end
      if (doWrite && (awAddr_r == OFF_IRQ_MASK) && wStrb0_r) begin
        irqMask_r <= wData_r[IRQ_W-1:0];
      end
    end
  end

  assign reqPartial = ctrlWr && wData_r[CTRL_REQ_PARTIAL];
  assign reqSlumber = ctrlWr && wData_r[CTRL_REQ_SLUMBER];
  assign reqWake = ctrlWr && wData_r[CTRL_WAKE];

  // ==========================================================================
  // AXI4-Lite read channel.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTRL: s_axi_rdata <= {31'h0000_0000, pmEnable_r};
        OFF_STATUS: s_axi_rdata <= {26'h000_0000, phyRdyS, modeSlumber_r, state_r};
        OFF_IRQ_STAT: s_axi_rdata <= {28'h000_0000, irqStat_r};
        OFF_IRQ_MASK: s_axi_rdata <= {28'h000_0000, irqMask_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Next-state logic.
  assign inReq = (state_r == ST_PARTIAL_REQ) || (state_r == ST_SLUMBER_REQ);
  assign rxPmReq = (rxPrim == PRIM_PMREQ_P) || (rxPrim == PRIM_PMREQ_S);
  assign abortEv = inReq && phyRdyS && (rxPrim == PRIM_X_RDY); // R4
  assign errEv = ((inReq || (state_r == ST_POWER_DENY)) && !phyRdyS) // R8
      || ((state_r == ST_SECOND_WAKEUP) && !phyRdyS); // R17
  assign sleepReq = (state_nxt == ST_PHY_READY_CHECK) || (state_nxt == ST_POWERED_DOWN_NOCOMM);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rxPmReq) begin
          state_nxt = pmEnable_r ? ST_POWER_OFF_ACK : ST_POWER_DENY; // R18 R9 R11
        end else if (reqPartial) begin
          state_nxt = ST_PARTIAL_REQ; // R1
        end else if (reqSlumber) begin
          state_nxt = ST_SLUMBER_REQ; // R2
        end
      end
      ST_PARTIAL_REQ, ST_SLUMBER_REQ: begin
        if (!phyRdyS) begin
          state_nxt = ST_NOCOMM_ERROR; // R8
        end else begin
          case (rxPrim)
            PRIM_PMACK: state_nxt = ST_PHY_READY_CHECK; // R3
            PRIM_X_RDY: state_nxt = ST_RECEIVE_WAIT_FIFO; // R4
            PRIM_SYNC, PRIM_R_OK: state_nxt = state_r; // R5
            PRIM_PMREQ_P, PRIM_PMREQ_S: state_nxt = IS_HOST ? ST_IDLE : state_r; // R6
            default: state_nxt = ST_IDLE; // R7
          endcase
        end
      end
      ST_POWER_OFF_ACK: begin
        if (ackCnt_r == ACK_LAST) begin
          state_nxt = ST_PHY_READY_CHECK; // R10
        end
      end
      ST_POWER_DENY: begin
        if (!phyRdyS) begin
          state_nxt = ST_NOCOMM_ERROR; // R8
        end else if (!rxPmReq) begin
          state_nxt = ST_IDLE; // R12
        end
      end
      ST_PHY_READY_CHECK: begin
        if (!phyRdyS) begin
          state_nxt = ST_POWERED_DOWN_NOCOMM; // R13
        end
      end
      ST_POWERED_DOWN_NOCOMM: begin
        if (reqWake || comWakeS) begin
          state_nxt = ST_FIRST_WAKEUP; // R14
        end
      end
      ST_FIRST_WAKEUP: begin
        if (phyRdyS) begin
          state_nxt = ST_SECOND_WAKEUP; // R15
        end
      end
      ST_SECOND_WAKEUP: begin
        state_nxt = phyRdyS ? ST_IDLE : ST_NOCOMM_ERROR; // R16 R17
      end
      ST_RECEIVE_WAIT_FIFO: state_nxt = ST_IDLE;
      ST_NOCOMM_ERROR: begin
        if (phyRdyS) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // State, mode flag and acknowledge counter.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      modeSlumber_r <= 1'b0;
      ackCnt_r <= 2'h0;
    end else begin
      if (state_r == ST_IDLE) begin
        if (rxPmReq) begin
          modeSlumber_r <= (rxPrim == PRIM_PMREQ_S); // R9
        end else if (reqPartial || reqSlumber) begin
          modeSlumber_r <= !reqPartial;
        end
      end
      ackCnt_r <= (state_r == ST_POWER_OFF_ACK) ? ackCnt_r + 2'h1 : 2'h0; // R10
    end
  end

  // ==========================================================================
  // Transmit primitive and phy power requests.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txPrim <= PRIM_SYNC;
      phyPartial <= 1'b0;
      phySlumber <= 1'b0;
    end else begin
      case (state_nxt)
        ST_PARTIAL_REQ: txPrim <= PRIM_PMREQ_P; // R1
        ST_SLUMBER_REQ: txPrim <= PRIM_PMREQ_S; // R2
        ST_POWER_OFF_ACK: txPrim <= PRIM_PMACK; // R9
        ST_POWER_DENY: txPrim <= PRIM_PMNACK; // R11
        ST_SECOND_WAKEUP: txPrim <= PRIM_ALIGN; // R16
        default: txPrim <= PRIM_SYNC;
      endcase
      phyPartial <= sleepReq && !modeSlumber_r; // R13 R15
      phySlumber <= sleepReq && modeSlumber_r; // R13 R15
    end
  end

  // ==========================================================================
  // Transport indications and interrupts.
  assign irqEv = {(state_r == ST_SECOND_WAKEUP) && phyRdyS,
                  (state_r == ST_PHY_READY_CHECK) && !phyRdyS,
                  errEv, abortEv};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pmAbort <= 1'b0;
      linkErr <= 1'b0;
      rcvStart <= 1'b0;
      irqStat_r <= '0;
      irq <= 1'b0;
    end else begin
      pmAbort <= abortEv; // R4
      linkErr <= errEv; // R8 R17
      rcvStart <= abortEv;
      if (doWrite && (awAddr_r == OFF_IRQ_STAT) && wStrb0_r) begin
        irqStat_r <= (irqStat_r & ~wData_r[IRQ_W-1:0]) | irqEv;
      end else begin
        irqStat_r <= irqStat_r | irqEv;
      end
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  // ==========================================================================
  // Checks.
  sequence ackRun;
    (state_r == ST_POWER_OFF_ACK && txPrim == PRIM_PMACK) [*4];
  endsequence

  sequence enterOff;
    state_r != ST_POWER_OFF_ACK ##1 state_r == ST_POWER_OFF_ACK;
  endsequence

  AST_REQ_TX: assert property (@(posedge clock) disable iff (!rstn) // R1
    (state_r == ST_PARTIAL_REQ) |-> (txPrim == PRIM_PMREQ_P))
    else $error("Partial request not sent.");
  AST_SLUMBER_TX: assert property (@(posedge clock) disable iff (!rstn) // R2
    (state_r == ST_SLUMBER_REQ) |-> (txPrim == PRIM_PMREQ_S))
    else $error("Slumber request not sent.");
  AST_PMACK_GO: assert property (@(posedge clock) disable iff (!rstn) // R3
    (inReq && phyRdyS && rxPrim == PRIM_PMACK) |=> (state_r == ST_PHY_READY_CHECK))
    else $error("PMACK did not reach phy check.");
  AST_XRDY_ABORT: assert property (@(posedge clock) disable iff (!rstn) // R4
    (inReq && phyRdyS && rxPrim == PRIM_X_RDY)
      |=> (state_r == ST_RECEIVE_WAIT_FIFO) && pmAbort)
    else $error("X_RDY abort missing.");
  AST_SYNC_HOLD: assert property (@(posedge clock) disable iff (!rstn) // R5
    (inReq && phyRdyS && (rxPrim == PRIM_SYNC || rxPrim == PRIM_R_OK)) |=> $stable(state_r))
    else $error("Request state left on SYNC.");
  AST_PHY_LOSS: assert property (@(posedge clock) disable iff (!rstn) // R8
    ((inReq || state_r == ST_POWER_DENY) && !phyRdyS)
      |=> (state_r == ST_NOCOMM_ERROR) && linkErr)
    else $error("Phy loss not reported.");
  AST_FOUR_ACKS: assert property (@(posedge clock) disable iff (!rstn) // R10
    enterOff |-> ackRun ##1 (state_r == ST_PHY_READY_CHECK))
    else $error("PMACK count wrong.");
  AST_DENY: assert property (@(posedge clock) disable iff (!rstn) // R11
    (state_r == ST_IDLE && rxPmReq && !pmEnable_r)
      |=> (state_r == ST_POWER_DENY) && (txPrim == PRIM_PMNACK))
    else $error("Disabled request not denied.");
  AST_CHK_DRIVE: assert property (@(posedge clock) disable iff (!rstn) // R13
    (state_r == ST_PHY_READY_CHECK) |-> (phySlumber == modeSlumber_r) && (phyPartial != phySlumber))
    else $error("Phy power request wrong.");
  AST_WAKE1_OFF: assert property (@(posedge clock) disable iff (!rstn) // R15
    (state_r == ST_FIRST_WAKEUP) |-> !phyPartial && !phySlumber)
    else $error("Power request held during wakeup.");
  AST_WAKE2_ERR: assert property (@(posedge clock) disable iff (!rstn) // R17
    (state_r == ST_SECOND_WAKEUP && !phyRdyS) |=> (state_r == ST_NOCOMM_ERROR) && linkErr)
    else $error("Wakeup phy loss not reported.");

endmodule : link_power_fsm

// *** verilog/link_pm_pkg.sv ***
// Purpose: Shared constants and types for the link power-mode controller.
// Assumes: 32-bit AXI4-Lite register window with 8 decoded address bits.
// Notes: Primitive codes are an abstract decoding supplied by the receive path.

package link_pm_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;

  // ==========================================================================
  // Field positions.
  localparam int CTRL_PM_EN = 0;
  localparam int CTRL_REQ_PARTIAL = 1;
  localparam int CTRL_REQ_SLUMBER = 2;
  localparam int CTRL_WAKE = 3;
  localparam int STAT_MODE_SLUMBER = 4;
  localparam int STAT_PHY_RDY = 5;
  localparam int IRQ_ABORT = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_ASLEEP = 2;
  localparam int IRQ_AWAKE = 3;
  localparam int IRQ_W = 4;

  // ==========================================================================
  // Reset values and counts.
  localparam logic RST_PM_EN = 1'b0;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic [1:0] ACK_LAST = 2'h3;
  localparam int SYNC_STAGES = 3;

  // ==========================================================================
  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================================
  // Link primitives as decoded by the receive path.
  typedef enum logic [3:0] {
    PRIM_OTHER, PRIM_SYNC, PRIM_R_OK, PRIM_X_RDY, PRIM_PMACK,
    PRIM_PMNACK, PRIM_PMREQ_P, PRIM_PMREQ_S, PRIM_ALIGN
  } prim_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PARTIAL_REQ, ST_SLUMBER_REQ, ST_POWER_OFF_ACK, ST_POWER_DENY,
    ST_PHY_READY_CHECK, ST_POWERED_DOWN_NOCOMM, ST_FIRST_WAKEUP,
    ST_SECOND_WAKEUP, ST_RECEIVE_WAIT_FIFO, ST_NOCOMM_ERROR
  } pm_state_t;

endpackage : link_pm_pkg

// *** verilog/pin_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter for phy inputs.
// Assumes: Inputs are asynchronous to clock.
// Notes: The output follows once the second and third stages agree.

`timescale 1ns/100ps

module pin_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // ==========================================================================
  // Stages.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ==========================================================================
  // Filter.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end

endmodule : pin_sync

// *** sim/link_far_end.sv ***
// Purpose: Far link end and local phy model for the power-mode bench.
// Assumes: The bench picks the idle primitive and whether requests get acknowledged.
// Notes: The phy sleeps after 5 request cycles and wakes 9 cycles after release.

`timescale 1ns/100ps

module link_far_end
  import link_pm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire prim_t txPrim,
  input wire logic phyPartial,
  input wire logic phySlumber,
  input wire prim_t holdPrim,
  input wire logic ackOn,
  input wire logic [3:0] ackWait,
  input wire logic phyKill,
  output prim_t rxPrim,
  output logic phyRdy
);
  logic [3:0] reqCount_r;
  logic [3:0] phyCount_r;
  logic phyUp_r;
  logic lowReq;
  logic phyMove;

  // ==========================================================================
  // Far link: acknowledges a power request once it has lasted ackWait cycles.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reqCount_r <= 4'h0;
      rxPrim <= PRIM_SYNC;
    end else if (ackOn && (txPrim == PRIM_PMREQ_P || txPrim == PRIM_PMREQ_S)) begin
      if (reqCount_r >= ackWait) begin
        rxPrim <= PRIM_PMACK;
      end else begin
        reqCount_r <= reqCount_r + 4'h1;
        rxPrim <= holdPrim;
      end
    end else begin
      reqCount_r <= 4'h0;
      rxPrim <= holdPrim;
    end
  end

  // ==========================================================================
  // Phy: sleeps while asked to, wakes when both requests are released.
  assign lowReq = phyPartial || phySlumber;
  assign phyMove = phyUp_r ? lowReq : !lowReq;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phyUp_r <= 1'b1;
      phyCount_r <= 4'h0;
    end else if (!phyMove) begin
      phyCount_r <= 4'h0;
    end else if (phyCount_r == (phyUp_r ? 4'h4 : 4'h8)) begin
      phyUp_r <= !phyUp_r;
      phyCount_r <= 4'h0;
    end else begin
      phyCount_r <= phyCount_r + 4'h1;
    end
  end
  assign phyRdy = phyUp_r && !phyKill;
endmodule : link_far_end

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the link power-mode controller.
// Assumes: Device-side build; registers reached over AXI4-Lite.
// Notes: Each scenario is a task that judges its own results.

`timescale 1ns/100ps

module testbench;
  import link_pm_pkg::*;
  logic clock, rstn, awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady, phyRdy, comWake, phyPartial, phySlumber;
  logic pmAbort, linkErr, rcvStart, irq, ackOn, phyKill;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData, d;
  logic [3:0] wStrb, ackWait;
  logic [1:0] bResp, rResp;
  prim_t rxPrim, txPrim, holdPrim;
  int failCount, checksDone, n;

  link_power_fsm link_power_fsm_i (.clock(clock), .rstn(rstn), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .rxPrim(rxPrim), .txPrim(txPrim), .phyRdy(phyRdy),
    .comWake(comWake), .phyPartial(phyPartial), .phySlumber(phySlumber),
    .pmAbort(pmAbort), .linkErr(linkErr), .rcvStart(rcvStart), .irq(irq));
  link_far_end link_far_end_i (.clock(clock), .rstn(rstn), .txPrim(txPrim),
    .phyPartial(phyPartial), .phySlumber(phySlumber), .holdPrim(holdPrim),
    .ackOn(ackOn), .ackWait(ackWait), .phyKill(phyKill), .rxPrim(rxPrim),
    .phyRdy(phyRdy));

  // ==========================================================================
  // Shared tasks.
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int k;
    k = 0;
    awAddr <= a;
    wData <= v;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clock);
      k++;
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (bValid !== 1'b1 && k < 100);
    check("bvalid", 32'h1, {31'h0, bValid});
    check("bresp", {30'h0, er}, {30'h0, bResp});
    bReady <= 1'b0;
    @(posedge clock);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [1:0] er);
    int k;
    k = 0;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clock);
      k++;
      if (arValid && arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1 && k < 100);
    d = rData;
    check("rvalid", 32'h1, {31'h0, rValid});
    check("rresp", {30'h0, er}, {30'h0, rResp});
    rReady <= 1'b0;
    @(posedge clock);
  endtask : axi_read

  function automatic logic pick(input int s);
    case (s)
      0: pick = phySlumber;
      1: pick = irq;
      2: pick = pmAbort;
      3: pick = linkErr;
      default: pick = phyRdy;
    endcase
  endfunction : pick

  task automatic wait_sig(input string what, input int s, input logic lvl);
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pick(s) !== lvl && k < 300);
    check(what, {31'h0, lvl}, {31'h0, pick(s)});
  endtask : wait_sig

  task automatic wait_tx(input prim_t p);
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (txPrim !== p && k < 300);
    check("txPrim", 32'(p), 32'(txPrim));
  endtask : wait_tx

  task automatic keep_tx(input prim_t p, input int k);
    repeat (k) begin
      @(posedge clock);
      check("txPrim held", 32'(p), 32'(txPrim));
    end
  endtask : keep_tx

  // ==========================================================================
  // Scenarios.
  task automatic t_regs;
    axi_read(OFF_CTRL, RESP_OKAY);
    check("ctrl reset", 32'h0, d);
    axi_read(OFF_IRQ_MASK, RESP_OKAY);
    check("mask reset", 32'h0, d);
    axi_read(8'h10, RESP_DECERR);
    axi_write(8'h14, 32'h1, RESP_DECERR);
    axi_write(OFF_IRQ_MASK, 32'hF, RESP_OKAY);
    axi_read(OFF_IRQ_MASK, RESP_OKAY);
    check("mask rw", 32'hF, d);
    $display("test regs done");
  endtask : t_regs

  task automatic t_slumber;
    ackOn <= 1'b1;
    ackWait <= 4'h6;
    axi_write(OFF_CTRL, 32'h5, RESP_OKAY);
    wait_tx(PRIM_PMREQ_S);
    keep_tx(PRIM_PMREQ_S, 3);
    wait_sig("phySlumber", 0, 1'b1);
    check("phyPartial", 32'h0, {31'h0, phyPartial});
    wait_sig("irq", 1, 1'b1);
    axi_read(OFF_STATUS, RESP_OKAY);
    check("status", 32'h10 | 32'(ST_POWERED_DOWN_NOCOMM), d);
    check("phySlumber held", 32'h1, {31'h0, phySlumber});
    axi_write(OFF_IRQ_STAT, 32'hF, RESP_OKAY);
    check("irq cleared", 32'h0, {31'h0, irq});
    axi_write(OFF_CTRL, 32'h9, RESP_OKAY);
    wait_sig("phySlumber", 0, 1'b0);
    wait_tx(PRIM_ALIGN);
    wait_tx(PRIM_SYNC);
    axi_read(OFF_STATUS, RESP_OKAY);
    check("state", 32'(ST_IDLE), {28'h0, d[3:0]});
    $display("test slumber done");
  endtask : t_slumber

  task automatic t_incoming;
    ackOn <= 1'b0;
    holdPrim <= PRIM_PMREQ_P;
    wait_tx(PRIM_PMACK);
    holdPrim <= PRIM_SYNC;
    n = 1;
    do begin
      @(posedge clock);
      if (txPrim === PRIM_PMACK) n++;
    end while (txPrim === PRIM_PMACK && n < 10);
    check("pmack count", 32'h4, 32'(n));
    check("phyPartial", 32'h1, {31'h0, phyPartial});
    wait_sig("phyRdy", 4, 1'b0);
    repeat (6) @(posedge clock);
    comWake <= 1'b1;
    wait_tx(PRIM_ALIGN);
    comWake <= 1'b0;
    wait_tx(PRIM_SYNC);
    $display("test incoming done");
  endtask : t_incoming

  task automatic t_deny;
    axi_write(OFF_CTRL, 32'h0, RESP_OKAY);
    holdPrim <= PRIM_PMREQ_S;
    wait_tx(PRIM_PMNACK);
    keep_tx(PRIM_PMNACK, 4);
    holdPrim <= PRIM_SYNC;
    wait_tx(PRIM_SYNC);
    axi_read(OFF_STATUS, RESP_OKAY);
    check("state", 32'(ST_IDLE), {28'h0, d[3:0]});
    $display("test deny done");
  endtask : t_deny

  task automatic t_abort;
    holdPrim <= PRIM_R_OK;
    axi_write(OFF_CTRL, 32'h3, RESP_OKAY);
    wait_tx(PRIM_PMREQ_P);
    keep_tx(PRIM_PMREQ_P, 4);
    holdPrim <= PRIM_X_RDY;
    wait_sig("pmAbort", 2, 1'b1);
    check("rcvStart", 32'h1, {31'h0, rcvStart});
    holdPrim <= PRIM_SYNC;
    axi_read(OFF_IRQ_STAT, RESP_OKAY);
    check("abort flag", 32'h1, {31'h0, d[IRQ_ABORT]});
    axi_write(OFF_IRQ_STAT, 32'hF, RESP_OKAY);
    $display("test abort done");
  endtask : t_abort

  task automatic t_loss;
    axi_write(OFF_CTRL, 32'h5, RESP_OKAY);
    wait_tx(PRIM_PMREQ_S);
    holdPrim <= PRIM_PMNACK;
    wait_tx(PRIM_SYNC);
    holdPrim <= PRIM_SYNC;
    axi_write(OFF_CTRL, 32'h5, RESP_OKAY);
    wait_tx(PRIM_PMREQ_S);
    holdPrim <= PRIM_PMREQ_P;
    keep_tx(PRIM_PMREQ_S, 4);
    phyKill <= 1'b1;
    wait_sig("linkErr", 3, 1'b1);
    phyKill <= 1'b0;
    holdPrim <= PRIM_SYNC;
    repeat (12) @(posedge clock);
    axi_read(OFF_STATUS, RESP_OKAY);
    check("state", 32'(ST_IDLE), {28'h0, d[3:0]});
    $display("test loss done");
  endtask : t_loss

  // ==========================================================================
  // Run control.
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tallyAndFinish

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    #400000;
    failCount++;
    tallyAndFinish;
  end

  initial begin
    rstn = 1'b0;
    {awValid, wValid, bReady, arValid, rReady, comWake, ackOn, phyKill} = 8'h00;
    awAddr = 8'h00;
    arAddr = 8'h00;
    wData = 32'h0;
    wStrb = 4'hF;
    ackWait = 4'h0;
    holdPrim = PRIM_SYNC;
    failCount = 0;
    checksDone = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (5) @(posedge clock);
    t_regs;
    t_slumber;
    t_incoming;
    t_deny;
    t_abort;
    t_loss;
    tallyAndFinish;
  end
endmodule : testbench
